// file: logic/spsl_pkg.sv
// Constants, field layout and decoders for the sensor parameter word
// What this block does
// R1: Sixteen bits shifted, least significant first
// R2: Data sampled on each serial clock rise
// R3: Select rise loads word; raised after sixteen
// R4: Controller uploads only at frame start
// R5: Bit 1 powers the pixel array
// R6: Bits 2..5 power amplifiers 4..1
// R7: Bits 6..8 choose X subsampling mode
// R8: Bits 9..11 choose Y subsampling mode
// R9: Bit 12 loads crossbar at row sync
// R10: Crossbar one swaps outputs pairwise
// R11: Bit 13 toggles crossbar each row clock
// R12: Bit 15 powers the sensor array
// R13: Full resolution word is decimal 33342
// R14: Parameter register has no defined power-up value; here reset loads PARAM_RST, all zero
// R15: Controller writes zero to bits 0, 14
// R16: Upload finishes before pointer row syncs
// R17: Row sync resets crossbar on row clock
package spsl_pkg;

    localparam int WORD_W = 16;
    localparam int BIT_CNT_W = 5;
    localparam int CNT_W = 4;

    // Field positions
    localparam int F_ZERO = 0;
    localparam int F_ARRAY_PWR = 1;
    localparam int F_AMP_LO = 2;
    localparam int F_X_LO = 6;
    localparam int F_Y_LO = 9;
    localparam int F_XBAR_INIT = 12;
    localparam int F_XBAR_TOGGLE = 13;
    localparam int F_UNUSED = 14;
    localparam int F_SENSOR_PWR = 15;
    localparam int MODE_W = 3;
    localparam int AMP_N = 4;

    // Values
    localparam logic [WORD_W-1:0] FULL_RES_WORD = 16'h823E;
    localparam logic [WORD_W-1:0] MUST_ZERO_MASK = 16'h4001;
    localparam logic [WORD_W-1:0] PARAM_RST = 16'h0000;
    localparam logic [BIT_CNT_W-1:0] BITS_PER_WORD = 5'h10;

    // Timing of the serial link
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_MIN_NS = 100;
    localparam int SETUP_NS = 50;
    localparam int HOLD_NS = 50;
    localparam int HALF_NS = (SCLK_MIN_NS / 2 > SETUP_NS) ?
                             SCLK_MIN_NS / 2 : SETUP_NS;
    localparam int HALF_CYC = (HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] HALF_LOAD = CNT_W'(HALF_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LOAD = CNT_W'(2 * HALF_CYC - 1);

    // Synchroniser lanes and their idle levels
    localparam int PIN_N = 3;
    localparam int P_CS_N = 0;
    localparam int P_ROW_CLK = 1;
    localparam int P_ROW_SYNC_N = 2;
    localparam logic [PIN_N-1:0] PIN_IDLE = 3'h5;

    // Decoded mode: {full, select[2:0], skip[4:0]}
    localparam int DEC_W = 9;

    // X code: 011 sel4 skip20, 100 sel4 skip4, 101 sel4 skip8, else full
    function automatic logic [DEC_W-1:0] x_decode(input logic [2:0] c);
        logic [DEC_W-1:0] d;
        d = {1'h1, 3'h0, 5'h00};
        case (c)
            3'h3: d = {1'h0, 3'h4, 5'h14};
            3'h4: d = {1'h0, 3'h4, 5'h04};
            3'h5: d = {1'h0, 3'h4, 5'h08};
            default: d = {1'h1, 3'h0, 5'h00};
        endcase
        return d;
    endfunction

    // Y code: 001 full, 011 sel2 skip4, 110/111 full, others sel2 skip2
    function automatic logic [DEC_W-1:0] y_decode(input logic [2:0] c);
        logic [DEC_W-1:0] d;
        d = {1'h1, 3'h0, 5'h00};
        case (c)
            3'h0, 3'h2, 3'h4, 3'h5: d = {1'h0, 3'h2, 5'h02};
            3'h3: d = {1'h0, 3'h2, 5'h04};
            default: d = {1'h1, 3'h0, 5'h00};
        endcase
        return d;
    endfunction

endpackage

// file: logic/spsl_if.sv
// Three-wire serial link between controller and sensor
`timescale 1ns/1ns
interface spsl_if;
    logic sclk;
    logic sdata;
    logic cs_n;

    modport ctrl (
        output sclk,
        output sdata,
        output cs_n
    );

    modport sensor (
        input sclk,
        input sdata,
        input cs_n
    );
endinterface

// file: logic/spsl_sensor.sv
// Sensor end: serial shift chain, parameter register and crossbar
`timescale 1ns/1ns
module spsl_sensor #(
    parameter int BUS_W = 8
) (
    input  wire logic                    clock,
    input  wire logic                    rst,
    spsl_if.sensor                       link,
    input  wire logic                    row_clk,
    input  wire logic                    row_sync_n,
    input  wire logic [4*BUS_W-1:0]      bus_in,
    output logic      [4*BUS_W-1:0]      amp_out,
    output logic      [15:0]             param_word,
    output logic                         sensor_power,
    output logic                         array_power,
    output logic      [3:0]              amp_power,
    output logic                         x_full,
    output logic      [2:0]              x_select,
    output logic      [4:0]              x_skip,
    output logic                         y_full,
    output logic      [2:0]              y_select,
    output logic      [4:0]              y_skip,
    output logic                         xbar_swap
);

    // Short names for the word width and the pin count
    localparam int W = spsl_pkg::WORD_W;
    localparam int N = spsl_pkg::PIN_N;

    // Link domain: the shift chain runs on the serial clock only
    // The chain keeps the last sixteen bits seen; extra clocks push the
    // oldest bits out, so a frame with too many bits keeps its tail
    logic [W-1:0] shift_ff;
    wire  [W-1:0] nxt_shift;

    // New bit enters at the top so the first bit ends up in bit 0
    assign nxt_shift = {link.sdata, shift_ff[W-1:1]};  // R1

    // Data only, so no reset: a stopped link clock could not apply one
    always_ff @(posedge link.sclk) begin
        shift_ff <= nxt_shift;  // R2
    end

    // Pin synchronisers: select, row clock, row sync
    // Three stages per pin; a level only counts once the second and
    // third stages agree, which keeps a metastable sample from making
    // a false edge
    logic [N-1:0] sync1_ff;
    logic [N-1:0] sync2_ff;
    logic [N-1:0] sync3_ff;
    logic [N-1:0] filt_ff;
    wire  [N-1:0] pins_in;
    wire  [N-1:0] agree;
    wire  [N-1:0] nxt_filt;
    wire  [N-1:0] rise;

    // One synchroniser lane per asynchronous pin
    assign pins_in[spsl_pkg::P_CS_N] = link.cs_n;
    assign pins_in[spsl_pkg::P_ROW_CLK] = row_clk;
    assign pins_in[spsl_pkg::P_ROW_SYNC_N] = row_sync_n;

    // Stage two and three must agree before a level counts
    assign agree = ~(sync2_ff ^ sync3_ff);

    // Filtered level and its rising edge, lane by lane
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            assign nxt_filt[g] = agree[g] ? sync3_ff[g] : filt_ff[g];
            assign rise[g] = nxt_filt[g] & ~filt_ff[g];
        end
    endgenerate

    // Stage one feeds stage two only
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1_ff <= spsl_pkg::PIN_IDLE;
            sync2_ff <= spsl_pkg::PIN_IDLE;
            sync3_ff <= spsl_pkg::PIN_IDLE;
            filt_ff <= spsl_pkg::PIN_IDLE;
        end else begin
            sync1_ff <= pins_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            filt_ff <= nxt_filt;
        end
    end

    // Parameter register, loaded on the select rise
    // The copy into the clock domain is taken as a whole word on the
    // select rise; no bit of it is synchronised on its own
    wire load;
    wire row_edge;
    wire row_sync_act;

    // Edges and levels taken from the filtered pins
    assign load = rise[spsl_pkg::P_CS_N];  // R3
    assign row_edge = rise[spsl_pkg::P_ROW_CLK];
    // Sync is low active and is taken as it stands at the row clock rise
    assign row_sync_act = ~filt_ff[spsl_pkg::P_ROW_SYNC_N];

    // Register copy of the word and its decoded modes
    logic [W-1:0] param_ff;
    logic [spsl_pkg::DEC_W-1:0] x_dec_ff;
    logic [spsl_pkg::DEC_W-1:0] y_dec_ff;
    wire  [spsl_pkg::DEC_W-1:0] nxt_x_dec;
    wire  [spsl_pkg::DEC_W-1:0] nxt_y_dec;

    // The shift word is quiet here: the link clock stands still while
    // select is high, and the synchroniser delay is far shorter than
    // the controller's gap before the next frame
    assign nxt_x_dec = spsl_pkg::x_decode(
        shift_ff[spsl_pkg::F_X_LO +: spsl_pkg::MODE_W]);  // R7
    assign nxt_y_dec = spsl_pkg::y_decode(
        shift_ff[spsl_pkg::F_Y_LO +: spsl_pkg::MODE_W]);  // R8

    // Reset gives a known word although the part itself powers up
    // undefined; every value is harmless so any choice is safe
    always_ff @(posedge clock) begin
        if (rst) begin
            param_ff <= spsl_pkg::PARAM_RST;  // R14
            x_dec_ff <= spsl_pkg::x_decode(3'h0);
            y_dec_ff <= spsl_pkg::y_decode(3'h0);
        end else if (load) begin
            param_ff <= shift_ff;  // R3
            x_dec_ff <= nxt_x_dec;  // R7
            y_dec_ff <= nxt_y_dec;  // R8
        end
    end

    // Power controls come straight from the parameter register
    // They follow the register directly, so power changes on the same clock
    // edge as the filtered select level rises
    wire [3:0] amp_bits;

    // Bit 2 is amplifier 4, bit 5 amplifier 1: reverse into amp index
    assign amp_bits = param_ff[spsl_pkg::F_AMP_LO +: spsl_pkg::AMP_N];
    generate
        for (g = 0; g < spsl_pkg::AMP_N; g++) begin : g_amp
            assign amp_power[g] = amp_bits[spsl_pkg::AMP_N-1-g];  // R6
        end
    endgenerate

    assign array_power = param_ff[spsl_pkg::F_ARRAY_PWR];  // R5
    assign sensor_power = param_ff[spsl_pkg::F_SENSOR_PWR];  // R12
    assign param_word = param_ff;

    // Decoded subsampling modes
    assign x_full = x_dec_ff[8];
    assign x_select = x_dec_ff[7:5];
    assign x_skip = x_dec_ff[4:0];
    assign y_full = y_dec_ff[8];
    assign y_select = y_dec_ff[7:5];
    assign y_skip = y_dec_ff[4:0];

    // Crossbar control bit
    // Row sync and row clock pass the same synchroniser, so the sync
    // level has settled by the time the row clock rise counts
    logic xbar_ff;
    wire  nxt_xbar;

    // Sync wins over toggling; with toggling off the bit just holds
    assign nxt_xbar =
        row_sync_act ? param_ff[spsl_pkg::F_XBAR_INIT] :  // R9 R17
        param_ff[spsl_pkg::F_XBAR_TOGGLE] ? ~xbar_ff :  // R11
        xbar_ff;

    // Crossbar bit steps only on a filtered row clock rise
    always_ff @(posedge clock) begin
        if (rst) begin
            xbar_ff <= 1'h0;
        end else if (row_edge) begin
            xbar_ff <= nxt_xbar;  // R17
        end
    end

    // Crossbar state as seen from outside
    assign xbar_swap = xbar_ff;

    // Output multiplexer: swap pairs 1/2 and 3/4 when the bit is set
    // Lane 0 carries bus 1 and output 1; lanes 2 and 3 swap as a pair
    // just as lanes 0 and 1 do
    // Registered lanes of the multiplexer and their next values
    logic [4*BUS_W-1:0] amp_out_ff;
    wire  [4*BUS_W-1:0] nxt_amp_out;

    generate
        for (g = 0; g < 4; g++) begin : g_xbar
            // Lane g takes its pair partner g^1 when swapped
            assign nxt_amp_out[g*BUS_W +: BUS_W] = xbar_ff ?
                bus_in[(g ^ 1)*BUS_W +: BUS_W] :
                bus_in[g*BUS_W +: BUS_W];  // R10
        end
    endgenerate

    // Registered so the lanes change together, one cycle after the bus
    always_ff @(posedge clock) begin
        if (rst) begin
            amp_out_ff <= '0;
        end else begin
            amp_out_ff <= nxt_amp_out;
        end
    end

    // Output lanes straight from their register
    assign amp_out = amp_out_ff;

endmodule

// file: logic/spsl_ctrl.sv
// Controller end: shifts a parameter word out over the serial link
`timescale 1ns/1ns
module spsl_ctrl (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         start,
    input  wire logic [15:0]  word,
    output logic              busy,
    output logic              done,
    spsl_if.ctrl              link
);

    localparam int W = spsl_pkg::WORD_W;
    localparam int CW = spsl_pkg::CNT_W;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_LOW  = 4'h2,
        S_HIGH = 4'h4,
        S_GAP  = 4'h8
    } spsl_state_t;

    spsl_state_t                      state_ff;
    logic [CW-1:0]                    cnt_ff;
    logic [spsl_pkg::BIT_CNT_W-1:0]   bits_ff;
    logic [W-1:0]                     word_ff;
    logic                             sclk_ff;
    logic                             sdata_ff;
    logic                             cs_n_ff;
    logic                             busy_ff;
    logic                             done_ff;

    wire [W-1:0] clean_word;
    wire         cnt_zero;
    wire         last_bit;

    // Reserved bits are forced low whatever the caller passes
    assign clean_word = word & ~spsl_pkg::MUST_ZERO_MASK;  // R15
    assign cnt_zero = (cnt_ff == '0);
    assign last_bit = (bits_ff == spsl_pkg::BITS_PER_WORD);  // R1

    // Data moves on the falling edge, half a period before the rise
    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= S_IDLE;
            cnt_ff <= '0;
            bits_ff <= '0;
            word_ff <= '0;
            sclk_ff <= 1'h0;
            sdata_ff <= 1'h0;
            cs_n_ff <= 1'h1;
            busy_ff <= 1'h0;
            done_ff <= 1'h0;
        end else begin
            done_ff <= 1'h0;
            if (!cnt_zero) begin
                cnt_ff <= cnt_ff - 1'h1;
            end
            case (state_ff)
                S_IDLE: begin
                    if (start) begin
                        word_ff <= clean_word;
                        sdata_ff <= clean_word[0];  // R1
                        cs_n_ff <= 1'h0;
                        bits_ff <= '0;
                        cnt_ff <= spsl_pkg::HALF_LOAD;
                        busy_ff <= 1'h1;  // R4 R16
                        state_ff <= S_LOW;
                    end
                end
                S_LOW: begin
                    if (cnt_zero && last_bit) begin
                        cs_n_ff <= 1'h1;  // R3
                        cnt_ff <= spsl_pkg::GAP_LOAD;
                        state_ff <= S_GAP;
                    end else if (cnt_zero) begin
                        sclk_ff <= 1'h1;  // R2
                        cnt_ff <= spsl_pkg::HALF_LOAD;
                        state_ff <= S_HIGH;
                    end
                end
                S_HIGH: begin
                    if (cnt_zero) begin
                        sclk_ff <= 1'h0;
                        bits_ff <= bits_ff + 1'h1;
                        word_ff <= {1'h0, word_ff[W-1:1]};
                        sdata_ff <= word_ff[1];  // R1
                        cnt_ff <= spsl_pkg::HALF_LOAD;
                        state_ff <= S_LOW;
                    end
                end
                S_GAP: begin
                    // Lets the sensor copy the word before a new frame
                    if (cnt_zero) begin
                        busy_ff <= 1'h0;
                        done_ff <= 1'h1;
                        state_ff <= S_IDLE;
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // Every link and status output comes from its own register
    assign link.sclk = sclk_ff;
    assign link.sdata = sdata_ff;
    assign link.cs_n = cs_n_ff;
    assign busy = busy_ff;
    assign done = done_ff;

endmodule

// file: tb/spsl_link_checker.sv
// Protocol assertions on the serial parameter link
`timescale 1ns/1ns
module spsl_link_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic cs_n
);
    logic [4:0] rise_cnt_ff;
    logic [4:0] nxt_rise_cnt;
    logic       sclk_d_ff;

    default clocking link_cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Rises within the current frame; cleared while deselected
    assign nxt_rise_cnt = cs_n ? 5'h00
                        : rise_cnt_ff + {4'h0, sclk & ~sclk_d_ff};

    // Counter state, reset with the controller
    always_ff @(posedge clock) begin
        if (rst) begin
            rise_cnt_ff <= 5'h00;
            sclk_d_ff <= 1'h0;
        end else begin
            rise_cnt_ff <= nxt_rise_cnt;
            sclk_d_ff <= sclk;
        end
    end

    a_idle_clock_low: assert property (cs_n |-> !sclk)
        else $error("serial clock active while deselected");
    a_lead_before_rise: assert property (
        $fell(cs_n) |-> !sclk [*5] ##1 sclk)
        else $error("first clock rise not five cycles after select");
    a_high_five: assert property ($rose(sclk) |-> sclk [*5] ##1 !sclk)
        else $error("serial clock high phase not five cycles");
    a_low_five: assert property ($fell(sclk) |-> !sclk [*5])
        else $error("serial clock low phase shorter than five cycles");
    a_data_held_high: assert property (sclk |-> $stable(sdata))
        else $error("data moved while serial clock high");
    a_bits_per_word: assert property ($rose(cs_n) |-> rise_cnt_ff == 5'h10)
        else $error("select raised after a count other than sixteen");
    a_count_capped: assert property (rise_cnt_ff <= 5'h10)
        else $error("more than sixteen clock rises in a frame");
    a_tail_before_load: assert property (
        $rose(cs_n) |-> $past(sclk, 6) && !$past(sclk, 5))
        else $error("select rise not five cycles after last fall");

    c_frame_start: cover property ($fell(cs_n));
    c_bit_shift: cover property ($rose(sclk));
    c_word_load: cover property ($rose(cs_n));
endmodule

// file: tb/testbench.sv
// Self-checking bench: controller and sensor ends joined by the link
`timescale 1ns/1ns
module testbench;
    logic        clock;
    logic        rst;
    logic        start;
    logic [15:0] word;
    logic        busy;
    logic        done;
    logic        row_clk;
    logic        row_sync_n;
    logic [31:0] bus_in;
    logic [31:0] amp_out;
    logic [15:0] param_word;
    logic        sensor_power;
    logic        array_power;
    logic [3:0]  amp_power;
    logic        x_full;
    logic [2:0]  x_select;
    logic [4:0]  x_skip;
    logic        y_full;
    logic [2:0]  y_select;
    logic [4:0]  y_skip;
    logic        xbar_swap;
    logic [15:0] cap;
    int          rises;
    int          bad_count;
    int          checked;

    // Both ends joined by the link, with the checker watching it
    spsl_if link_bus ();
    spsl_ctrl spsl_ctrl_inst (.clock(clock), .rst(rst), .start(start),
        .word(word), .busy(busy), .done(done), .link(link_bus.ctrl));
    spsl_sensor #(.BUS_W(8)) spsl_sensor_inst (.clock(clock), .rst(rst),
        .link(link_bus.sensor), .row_clk(row_clk), .row_sync_n(row_sync_n),
        .bus_in(bus_in), .amp_out(amp_out), .param_word(param_word),
        .sensor_power(sensor_power), .array_power(array_power),
        .amp_power(amp_power), .x_full(x_full), .x_select(x_select),
        .x_skip(x_skip), .y_full(y_full), .y_select(y_select),
        .y_skip(y_skip), .xbar_swap(xbar_swap));
    spsl_link_checker spsl_link_checker_inst (.clock(clock), .rst(rst),
        .sclk(link_bus.sclk), .sdata(link_bus.sdata), .cs_n(link_bus.cs_n));

    // System clock, 10 ns period
    always #5 clock = ~clock;

    // Listen on the wire as the sensor does: first bit ends at bit 0
    always @(posedge link_bus.sclk) begin
        cap = {link_bus.sdata, cap[15:1]};
        rises = rises + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Send one word; bits 0 and 14 always leave as zero
    task automatic send(input logic [15:0] w);
        int n;
        rises = 0;
        @(posedge clock);
        #1;
        start = 1'h1;
        word = w;
        @(posedge clock);
        #1;
        start = 1'h0;
        check(busy, 1'h1);
        n = 0;
        while (done !== 1'h1 && n < 300) begin
            @(posedge clock);
            #1;
            n = n + 1;
        end
        check(n < 300, 1'h1);
        check(rises, 16);
        check(cap, w & 16'hBFFE);
        check(param_word, w & 16'hBFFE);
    endtask

    // A start held for twenty cycles into the frame is ignored; the first word lands
    task automatic test_busy_start();
        int n;
        rises = 0;
        @(posedge clock);
        #1;
        start = 1'h1;
        word = 16'h0246;
        @(posedge clock);
        #1;
        word = 16'h1357;
        repeat (20) @(posedge clock);
        #1;
        start = 1'h0;
        n = 0;
        while (done !== 1'h1 && n < 300) begin
            @(posedge clock);
            #1;
            n = n + 1;
        end
        check(n < 300, 1'h1);
        check(rises, 16);
        check(param_word, 16'h0246);
    endtask

    // Every subsampling code, power bits walked alongside
    task automatic test_codes();
        logic [2:0] c;
        logic [8:0] xe;
        logic [8:0] ye;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            send({c[2], 3'h0, c, c, 4'h1 << c[1:0], c[0], 1'h0});
            case (c)
                3'h3: xe = {1'h0, 3'h4, 5'h14};
                3'h4: xe = {1'h0, 3'h4, 5'h04};
                3'h5: xe = {1'h0, 3'h4, 5'h08};
                default: xe = {1'h1, 3'h0, 5'h00};
            endcase
            case (c)
                3'h0, 3'h2, 3'h4, 3'h5: ye = {1'h0, 3'h2, 5'h02};
                3'h3: ye = {1'h0, 3'h2, 5'h04};
                default: ye = {1'h1, 3'h0, 5'h00};
            endcase
            check({x_full, x_select, x_skip}, xe);
            check({y_full, y_select, y_skip}, ye);
            check(amp_power, 4'h8 >> c[1:0]);
            check(array_power, c[0]);
            check(sensor_power, c[2]);
        end
    endtask

    // One row clock period; sync level held well across the rise
    task automatic row(input logic sync_n);
        row_sync_n = sync_n;
        repeat (4) @(posedge clock);
        #1;
        row_clk = 1'h1;
        repeat (4) @(posedge clock);
        #1;
        row_clk = 1'h0;
        repeat (6) @(posedge clock);
        #1;
        row_sync_n = 1'h1;
    endtask

    // Crossbar preset, hold and toggle; rows only after the upload
    task automatic test_xbar();
        send(16'h1000);
        row(1'h0);
        check(xbar_swap, 1'h1);
        check(amp_out, 32'h33441122);
        row(1'h1);
        check(xbar_swap, 1'h1);
        send(16'h2000);
        row(1'h0);
        check(xbar_swap, 1'h0);
        check(amp_out, 32'h44332211);
        row(1'h1);
        check(xbar_swap, 1'h1);
        row(1'h1);
        check(xbar_swap, 1'h0);
    endtask

    initial begin
        clock = 1'h0;
        rst = 1'h1;
        start = 1'h0;
        word = 16'h0000;
        row_clk = 1'h0;
        row_sync_n = 1'h1;
        bus_in = 32'h44332211;
        cap = 16'h0000;
        rises = 0;
        bad_count = 0;
        checked = 0;
        repeat (3) @(posedge clock);
        #1;
        rst = 1'h0;
        check(param_word, 16'h0000);
        send(spsl_pkg::FULL_RES_WORD);
        check({sensor_power, array_power, amp_power}, 6'h3F);
        check({x_full, y_full}, 2'h3);
        send(16'hFFFF);
        test_busy_start();
        test_codes();
        test_xbar();
        end_of_test();
    end

    // Run needs about 24 us; a hang is cut short well after that
    initial begin
        #60000;
        bad_count = bad_count + 1;
        end_of_test();
    end
endmodule
